// ==== include/i2ctp_pkg.sv ====
// Shared constants and types for the I2C register-pointer target and its host
package i2ctp_pkg;

  // Bus timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int SCL_PERIOD_NS = 2500;
  localparam int QTR_CYC_INT = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam int DIV_W = 8;
  localparam logic [DIV_W-1:0] QTR_LAST = DIV_W'(QTR_CYC_INT - 1);

  // Byte framing
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] RD_INC_SCL = 4'h5;
  localparam logic [1:0] PH_LAST = 2'h3;

  // Target address straps
  localparam logic [6:0] ADDR_BASE = 7'h08;
  localparam logic [2:0] ADDR_SEL_MAX = 3'h5;

  // Write queue
  localparam int WQ_DEPTH = 16;
  localparam int WQ_WIDTH = 16;

  // Host byte kinds
  typedef enum logic [2:0] {
    K_DEVW = 3'h0,
    K_REG  = 3'h1,
    K_WR   = 3'h3,
    K_DEVR = 3'h2,
    K_RD   = 3'h6
  } i2ctp_kind_e;

endpackage

// ==== include/i2ctp_bus_if.sv ====
// Open-drain SCL/SDA wires joining the host end and the target end
`timescale 1ns/1ps
`default_nettype none
interface i2ctp_bus_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic tgt_sda_o;
  logic tgt_sda_oe;
  logic scl;
  logic sda;

  // Wired-AND with external pull-ups
  assign scl = host_scl_oe ? host_scl_o : 1'b1;
  assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (tgt_sda_oe ? tgt_sda_o : 1'b1);

  modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
                output host_sda_o, output host_sda_oe);
  modport target (input scl, input sda, output tgt_sda_o, output tgt_sda_oe);
endinterface
`default_nettype wire

// ==== hdl/i2ctp_target.sv ====
// I2C target end with auto-incrementing register pointer and write queue
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module i2ctp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // Drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [CW-1:0] cnt_q;

  function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
    next_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  wire push_w = in_valid_i && in_ready_o;
  wire pop_w = (cnt_q != '0) && (!out_valid_o || out_ready_i);
  assign in_ready_o = (cnt_q != CW'(DEPTH));

  always_ff @(posedge clk_i)
  begin
    if (push_w)
    begin
      mem_q[wp_q] <= in_data_i;
    end
  end

  // Output stage registered so the drain side sees flops
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      out_valid_o <= 1'b0;
      out_data_o <= '0;
    end
    else
    begin
      if (push_w)
      begin
        wp_q <= next_ptr(wp_q);
      end
      if (pop_w)
      begin
        rp_q <= next_ptr(rp_q);
        out_data_o <= mem_q[rp_q];
        out_valid_o <= 1'b1;
      end
      else if (out_ready_i)
      begin
        out_valid_o <= 1'b0;
      end
      cnt_q <= cnt_q + CW'(push_w) - CW'(pop_w);
    end
  end
endmodule // i2ctp_fifo

////////////////////////////////////////////////////////////////////////////////
module i2ctp_target
  import i2ctp_pkg::*;
#(
  parameter int FIFO_DEPTH = WQ_DEPTH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Bus pins
  i2ctp_bus_if.target bus,
  // Power status and address strap
  input wire logic bias_power_good_i,
  input wire logic [2:0] addr_sel_i,
  // Register file read port
  output logic [7:0] rd_addr_o,
  input wire logic [7:0] rd_data_i,
  // Register write queue
  output logic wq_valid_o,
  output logic [7:0] wq_addr_o,
  output logic [7:0] wq_data_o,
  input wire logic wq_ready_i
);
  typedef enum logic [2:0] {
    TS_IDLE = 3'h0,
    TS_ADDR = 3'h1,
    TS_ACK  = 3'h3,
    TS_RX   = 3'h2,
    TS_TX   = 3'h6,
    TS_TACK = 3'h7
  } i2ctp_tstate_e;

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: {scl, sda, power good, strap}
  logic [5:0] meta_q;
  logic [5:0] sync_q;
  logic scl_d_q;
  logic sda_d_q;

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      meta_q <= 6'h38;
      sync_q <= 6'h38;
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
    end
    else
    begin
      meta_q <= {bus.scl, bus.sda, bias_power_good_i, addr_sel_i};
      sync_q <= meta_q;
      scl_d_q <= sync_q[5];
      sda_d_q <= sync_q[4];
    end
  end

  wire scl_w = sync_q[5];
  wire sda_w = sync_q[4];
  wire pg_w = sync_q[3];
  wire [2:0] sel_w = sync_q[2:0];
  wire scl_rise_w = scl_w && !scl_d_q;
  wire scl_fall_w = !scl_w && scl_d_q;
  wire start_w = scl_w && scl_d_q && sda_d_q && !sda_w;
  wire stop_w = scl_w && scl_d_q && !sda_d_q && sda_w;

  wire [2:0] sel_c_w = (sel_w > ADDR_SEL_MAX) ? ADDR_SEL_MAX : sel_w;
  wire [6:0] my_addr_w = ADDR_BASE + {4'h0, sel_c_w};

  //////////////////////////////////////////////////////////////////////////////
  // Byte engine
  i2ctp_tstate_e state_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic [7:0] ptr_q;
  logic go_tx_q;
  logic reg_pend_q;
  logic push_q;
  logic [15:0] push_data_q;
  logic sda_oe_q;
  logic wq_ready_w;

  wire byte_end_w = (bit_q == BYTE_BITS);
  wire addr_hit_w = (sh_q[7:1] == my_addr_w);
  wire inc_edge_w = (bit_q == RD_INC_SCL - 4'h1);

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      state_q <= TS_IDLE;
      bit_q <= '0;
      sh_q <= '0;
      ptr_q <= '0;
      go_tx_q <= 1'b0;
      reg_pend_q <= 1'b0;
      push_q <= 1'b0;
      push_data_q <= '0;
    end
    else
    begin
      push_q <= 1'b0;
      // Pointer kept across stop and start
      if (!pg_w || stop_w)
      begin
        state_q <= TS_IDLE;
      end
      else if (start_w)
      begin
        state_q <= TS_ADDR;
        bit_q <= '0;
      end
      else
      begin
        case (state_q)
          TS_ADDR, TS_RX:
          begin
            if (scl_rise_w)
            begin
              sh_q <= {sh_q[6:0], sda_w};
              bit_q <= bit_q + 4'h1;
            end
            else if (scl_fall_w && byte_end_w)
            begin
              if (state_q == TS_ADDR)
              begin
                if (addr_hit_w)
                begin
                  state_q <= TS_ACK;
                  go_tx_q <= sh_q[0];
                  reg_pend_q <= !sh_q[0];
                end
                else
                begin
                  state_q <= TS_IDLE;
                end
              end
              else if (reg_pend_q)
              begin
                ptr_q <= sh_q;
                reg_pend_q <= 1'b0;
                state_q <= TS_ACK;
              end
              else if (wq_ready_w)
              begin
                push_q <= 1'b1;
                push_data_q <= {ptr_q, sh_q};
                ptr_q <= ptr_q + 8'h1;
                state_q <= TS_ACK;
              end
              else
              begin
                // Queue full: refuse the byte
                state_q <= TS_IDLE;
              end
            end
          end
          TS_ACK:
          begin
            if (scl_fall_w)
            begin
              bit_q <= '0;
              sh_q <= rd_data_i;
              state_q <= go_tx_q ? TS_TX : TS_RX;
            end
          end
          TS_TX:
          begin
            if (scl_rise_w)
            begin
              bit_q <= bit_q + 4'h1;
              if (inc_edge_w)
              begin
                ptr_q <= ptr_q + 8'h1;
              end
            end
            else if (scl_fall_w)
            begin
              if (byte_end_w)
              begin
                state_q <= TS_TACK;
              end
              else
              begin
                sh_q <= {sh_q[6:0], 1'b0};
              end
            end
          end
          TS_TACK:
          begin
            if (scl_rise_w && sda_w)
            begin
              state_q <= TS_IDLE;
            end
            else if (scl_fall_w)
            begin
              bit_q <= '0;
              sh_q <= rd_data_i;
              state_q <= TS_TX;
            end
          end
          default:
          begin
            state_q <= TS_IDLE;
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Open-drain data drive, low only
  wire sda_oe_d = (state_q == TS_ACK) || ((state_q == TS_TX) && !sh_q[7]);

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      sda_oe_q <= 1'b0;
    end
    else
    begin
      sda_oe_q <= sda_oe_d && pg_w;
    end
  end

  assign bus.tgt_sda_oe = sda_oe_q;
  assign bus.tgt_sda_o = 1'b0;
  assign rd_addr_o = ptr_q;

  //////////////////////////////////////////////////////////////////////////////
  // Write queue toward the register file
  logic [15:0] wq_out_w;

  i2ctp_fifo #(
    .WIDTH(WQ_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_wq (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .in_valid_i(push_q),
    .in_data_i(push_data_q),
    .in_ready_o(wq_ready_w),
    .out_valid_o(wq_valid_o),
    .out_data_o(wq_out_w),
    .out_ready_i(wq_ready_i)
  );

  assign wq_addr_o = wq_out_w[15:8];
  assign wq_data_o = wq_out_w[7:0];
endmodule // i2ctp_target
`default_nettype wire

// ==== hdl/i2ctp_host.sv ====
// I2C host end: makes SCL, runs write and pointer-read transactions
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module i2ctp_host
  import i2ctp_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Bus pins
  i2ctp_bus_if.host bus,
  // Transaction command
  input wire logic cmd_valid_i,
  input wire logic cmd_read_i,
  input wire logic cmd_set_ptr_i,
  input wire logic [6:0] cmd_dev_i,
  input wire logic [7:0] cmd_reg_i,
  input wire logic [7:0] cmd_len_i,
  output logic cmd_ready_o,
  // Write data stream
  input wire logic wr_valid_i,
  input wire logic [7:0] wr_data_i,
  output logic wr_ready_o,
  // Read data and completion
  output logic rd_valid_o,
  output logic [7:0] rd_data_o,
  output logic done_o,
  output logic nack_o
);
  typedef enum logic [2:0] {
    HS_IDLE  = 3'h0,
    HS_START = 3'h1,
    HS_BYTE  = 3'h3,
    HS_WAIT  = 3'h2,
    HS_STOP  = 3'h6
  } i2ctp_hstate_e;

  //////////////////////////////////////////////////////////////////////////////
  // SDA synchroniser and quarter-period divider
  logic sda_m_q;
  logic sda_s_q;
  logic [DIV_W-1:0] div_q;
  i2ctp_hstate_e state_q;

  wire tick_w = (div_q == QTR_LAST) && (state_q != HS_IDLE) && (state_q != HS_WAIT);

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      div_q <= '0;
    end
    else
    begin
      sda_m_q <= bus.sda;
      sda_s_q <= sda_m_q;
      // Restart the quarter when leaving a wait, so it is never shortened
      div_q <= (tick_w || state_q == HS_IDLE || state_q == HS_WAIT) ? '0 : div_q + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transaction sequencer
  i2ctp_kind_e kind_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [7:0] tx_q;
  logic [7:0] rx_q;
  logic [7:0] cnt_q;
  logic [7:0] reg_q;
  logic [6:0] dev_q;
  logic read_q;
  logic ack_bad_q;
  logic scl_oe_q;
  logic sda_oe_q;

  wire rx_w = (kind_q == K_RD);
  wire last_w = (cnt_q == 8'h1);
  wire ph_end_w = tick_w && (ph_q == PH_LAST);
  wire byte_done_w = ph_end_w && (bit_q == BYTE_BITS);
  wire ack_drv_w = rx_w && !last_w;
  wire data_drv_w = !rx_w && !tx_q[7];
  wire bit_drv_w = (bit_q == BYTE_BITS) ? ack_drv_w : data_drv_w;
  wire direct_rd_w = cmd_read_i && !cmd_set_ptr_i;

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      state_q <= HS_IDLE;
      kind_q <= K_DEVW;
      ph_q <= '0;
      bit_q <= '0;
      tx_q <= '0;
      rx_q <= '0;
      cnt_q <= '0;
      reg_q <= '0;
      dev_q <= '0;
      read_q <= 1'b0;
      ack_bad_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      cmd_ready_o <= 1'b0;
      wr_ready_o <= 1'b0;
      rd_valid_o <= 1'b0;
      rd_data_o <= '0;
      done_o <= 1'b0;
      nack_o <= 1'b0;
    end
    else
    begin
      rd_valid_o <= 1'b0;
      done_o <= 1'b0;
      if (tick_w)
      begin
        ph_q <= ph_q + 2'h1;
      end
      case (state_q)
        HS_IDLE:
        begin
          cmd_ready_o <= 1'b1;
          if (cmd_valid_i && cmd_ready_o)
          begin
            // Pointer reload precedes a repeated read
            cmd_ready_o <= 1'b0;
            kind_q <= direct_rd_w ? K_DEVR : K_DEVW;
            tx_q <= {cmd_dev_i, direct_rd_w};
            dev_q <= cmd_dev_i;
            reg_q <= cmd_reg_i;
            cnt_q <= cmd_len_i;
            read_q <= cmd_read_i;
            ack_bad_q <= 1'b0;
            ph_q <= '0;
            state_q <= HS_START;
          end
        end
        HS_START:
        begin
          if (tick_w)
          begin
            case (ph_q)
              2'h0: sda_oe_q <= 1'b0;
              2'h1: scl_oe_q <= 1'b0;
              2'h2: sda_oe_q <= 1'b1;
              default:
              begin
                scl_oe_q <= 1'b1;
                bit_q <= '0;
                state_q <= HS_BYTE;
              end
            endcase
          end
        end
        HS_WAIT:
        begin
          wr_ready_o <= 1'b1;
          if (wr_valid_i && wr_ready_o)
          begin
            wr_ready_o <= 1'b0;
            tx_q <= wr_data_i;
            bit_q <= '0;
            ph_q <= '0;
            state_q <= HS_BYTE;
          end
        end
        HS_BYTE:
        begin
          if (tick_w)
          begin
            case (ph_q)
              2'h0: sda_oe_q <= bit_drv_w;
              2'h1: scl_oe_q <= 1'b0;
              2'h2:
              begin
                if (bit_q == BYTE_BITS)
                begin
                  ack_bad_q <= sda_s_q && !rx_w;
                end
                else
                begin
                  rx_q <= {rx_q[6:0], sda_s_q};
                end
              end
              default:
              begin
                scl_oe_q <= 1'b1;
                tx_q <= {tx_q[6:0], 1'b0};
                bit_q <= bit_q + 4'h1;
              end
            endcase
          end
          if (byte_done_w)
          begin
            bit_q <= '0;
            if (ack_bad_q)
            begin
              state_q <= HS_STOP;
            end
            else
            begin
              case (kind_q)
                K_DEVW:
                begin
                  kind_q <= K_REG;
                  tx_q <= reg_q;
                end
                K_REG:
                begin
                  if (read_q)
                  begin
                    kind_q <= K_DEVR;
                    tx_q <= {dev_q, 1'b1};
                    state_q <= HS_START;
                  end
                  else
                  begin
                    kind_q <= K_WR;
                    state_q <= (cnt_q == '0) ? HS_STOP : HS_WAIT;
                  end
                end
                K_WR:
                begin
                  cnt_q <= cnt_q - 8'h1;
                  state_q <= last_w ? HS_STOP : HS_WAIT;
                end
                K_DEVR:
                begin
                  kind_q <= K_RD;
                  state_q <= (cnt_q == '0) ? HS_STOP : HS_BYTE;
                end
                default:
                begin
                  rd_valid_o <= 1'b1;
                  rd_data_o <= rx_q;
                  cnt_q <= cnt_q - 8'h1;
                  state_q <= last_w ? HS_STOP : HS_BYTE;
                end
              endcase
            end
          end
        end
        HS_STOP:
        begin
          if (tick_w)
          begin
            case (ph_q)
              2'h0: sda_oe_q <= 1'b1;
              2'h1: scl_oe_q <= 1'b0;
              2'h2: sda_oe_q <= 1'b0;
              default:
              begin
                done_o <= 1'b1;
                nack_o <= ack_bad_q;
                state_q <= HS_IDLE;
              end
            endcase
          end
        end
        default:
        begin
          state_q <= HS_IDLE;
        end
      endcase
    end
  end

  assign bus.host_scl_oe = scl_oe_q;
  assign bus.host_sda_oe = sda_oe_q;
  assign bus.host_scl_o = 1'b0;
  assign bus.host_sda_o = 1'b0;
endmodule // i2ctp_host
`default_nettype wire

// ==== test/i2ctp_props.sv ====
// Assertions on the SCL and SDA drivers and on the joined SCL and SDA lines
`timescale 1ns/1ps
`default_nettype none
module i2ctp_props (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Bus signals
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic tgt_sda_o,
  input wire logic tgt_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  a_scl_open_drain: assert property (host_scl_o == 1'b0)
    else $error("host drives SCL high");
  a_sda_open_drain: assert property (!host_sda_o && !tgt_sda_o)
    else $error("SDA driven high");
  a_tgt_turn_low: assert property ($changed(tgt_sda_oe) |-> !scl)
    else $error("target SDA changed with SCL high");
  a_tgt_after_fall: assert property ($rose(tgt_sda_oe) |-> !$past(scl, 3))
    else $error("target drive too soon after SCL fall");
  a_tgt_drive_hold: assert property ($rose(tgt_sda_oe) |=> tgt_sda_oe [*8])
    else $error("target drive dropped early");
  a_scl_high_min: assert property ($rose(scl) |=> scl [*8])
    else $error("SCL high phase too short");
  a_scl_low_min: assert property ($fell(scl) |=> !scl [*8])
    else $error("SCL low phase too short");
  a_start_tgt_quiet: assert property (scl && $past(scl) && $fell(sda) |=> !tgt_sda_oe [*4])
    else $error("target drives right after START");
  a_stop_tgt_quiet: assert property (scl && $past(scl) && $rose(sda) |=> !tgt_sda_oe [*4])
    else $error("target drives right after STOP");
endmodule // i2ctp_props
`default_nettype wire

// ==== test/i2c_target_register_pointer_tb.sv ====
// Bench: host and target over one bus, a bit-banged second bus for aborts
`timescale 1ns/1ps
`default_nettype none
module i2c_target_register_pointer_tb
  import i2ctp_pkg::*;
;
  localparam int WQ_CAP = 5; // Depth 4 plus output register
  logic clk_i = 1'b0, rstn_i = 1'b0, stall_all = 1'b0;
  logic cmd_valid_i = 1'b0, cmd_read_i = 1'b0, cmd_set_ptr_i = 1'b0;
  logic [6:0] cmd_dev_i = 7'h08;
  logic [7:0] cmd_reg_i = 8'h00, cmd_len_i = 8'h00, wr_data_i = 8'h00;
  logic wr_valid_i = 1'b0, wq_ready_i = 1'b0, bias_power_good_i = 1'b1;
  logic [2:0] addr_sel_i = 3'h0;
  logic cmd_ready_o, wr_ready_o, rd_valid_o, done_o, nack_o, wq_valid_o;
  logic [7:0] rd_data_o, rd_addr_o, rd_data_i, wq_addr_o, wq_data_o, rd_addr_b;
  logic [7:0] regs [256];
  logic [7:0] wr_q [$], rd_got [$];
  logic [15:0] exp_wq [$];
  logic [8:0] log_q [$];
  logic [8:0] sh = 9'h000;
  logic [7:0] rnd = 8'h11, rq = 8'h11;
  logic scl_p = 1'b1, sda_p = 1'b1;
  int bitc = 0, fail_count = 0, compares = 0;

  i2ctp_bus_if bus_a ();
  i2ctp_bus_if bus_b ();
  assign rd_data_i = regs[rd_addr_o];
  initial forever #12.5 clk_i = ~clk_i;

  i2ctp_host i2ctp_host_inst (.clk_i, .rstn_i, .bus(bus_a), .cmd_valid_i, .cmd_read_i,
    .cmd_set_ptr_i, .cmd_dev_i, .cmd_reg_i, .cmd_len_i, .cmd_ready_o, .wr_valid_i,
    .wr_data_i, .wr_ready_o, .rd_valid_o, .rd_data_o, .done_o, .nack_o);
  i2ctp_target #(.FIFO_DEPTH(4)) i2ctp_target_inst (.clk_i, .rstn_i, .bus(bus_a),
    .bias_power_good_i, .addr_sel_i, .rd_addr_o, .rd_data_i, .wq_valid_o, .wq_addr_o,
    .wq_data_o, .wq_ready_i);
  i2ctp_target #(.FIFO_DEPTH(4)) i2ctp_target_inst_b (.clk_i, .rstn_i, .bus(bus_b),
    .bias_power_good_i, .addr_sel_i, .rd_addr_o(rd_addr_b), .rd_data_i(8'hff),
    .wq_valid_o(), .wq_addr_o(), .wq_data_o(), .wq_ready_i(1'b1));
  i2ctp_props i2ctp_props_inst (.clk_i, .rstn_i, .host_scl_o(bus_a.host_scl_o),
    .host_scl_oe(bus_a.host_scl_oe), .host_sda_o(bus_a.host_sda_o),
    .host_sda_oe(bus_a.host_sda_oe), .tgt_sda_o(bus_a.tgt_sda_o),
    .tgt_sda_oe(bus_a.tgt_sda_oe), .scl(bus_a.scl), .sda(bus_a.sda));

  ////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic give_verdict();
    if (fail_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask
  task automatic chk_log(input int i, input logic [7:0] b, input logic a);
    chk_val(log_q.size() > i ? log_q[i][8:1] : 8'hxx, b);
    chk_flag(log_q.size() > i ? log_q[i][0] : 1'bx, a);
  endtask
  task automatic run(input logic rd, input logic sp, input logic [6:0] dev,
                     input logic [7:0] rg, input logic [7:0] ln);
    int n;
    cmd_read_i = rd;
    cmd_set_ptr_i = sp;
    cmd_dev_i = dev;
    cmd_reg_i = rg;
    cmd_len_i = ln;
    cmd_valid_i = 1'b1;
    n = 0;
    while (cmd_ready_o !== 1'b1 && n < 100)
    begin
      @(posedge clk_i);
      #1 n++;
    end
    @(posedge clk_i);
    #1 cmd_valid_i = 1'b0;
    n = 0;
    while (done_o !== 1'b1 && n < 20000)
    begin
      @(posedge clk_i);
      #1 n++;
    end
    chk_flag(done_o, 1'b1);
  endtask
  task automatic drain_wait();
    int n;
    n = 0;
    while (exp_wq.size() > 0 && n < 5000)
    begin
      @(posedge clk_i);
      #1 n++;
    end
    chk_flag(n < 5000, 1'b1);
  endtask
  // Bit-banged quarter on the second bus: oe high pulls low
  task automatic qq(input logic c, input logic d);
    bus_b.host_scl_oe = c;
    bus_b.host_sda_oe = d;
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  task automatic bbit(input logic b, output logic s);
    qq(1'b1, !b);
    qq(1'b0, !b);
    s = bus_b.sda;
    qq(1'b0, !b);
    qq(1'b1, !b);
  endtask
  task automatic bbyte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bbit(v[i], s);
    bbit(1'b1, ack);
  endtask

  ////////////////////////////////////////
  always @(posedge clk_i)
  begin
    if (wr_valid_i && wr_ready_o === 1'b1)
      void'(wr_q.pop_front());
    #1 wr_valid_i = wr_q.size() > 0;
    wr_data_i = wr_q.size() > 0 ? wr_q[0] : 8'h00;
  end
  always @(posedge clk_i)
  begin
    if (wq_valid_o === 1'b1 && wq_ready_i)
    begin
      chk_val(wq_addr_o, exp_wq.size() > 0 ? exp_wq[0][15:8] : 8'hxx);
      chk_val(wq_data_o, exp_wq.size() > 0 ? exp_wq[0][7:0] : 8'hxx);
      if (exp_wq.size() > 0)
        void'(exp_wq.pop_front());
      regs[wq_addr_o] = wq_data_o;
    end
    #1 rq = lfsr(rq);
    wq_ready_i = !stall_all && rq[0];
  end
  always @(posedge clk_i)
    if (rd_valid_o === 1'b1)
      rd_got.push_back(rd_data_o);
  // Byte and acknowledge log of the first bus, cleared at each START
  always @(posedge clk_i)
  begin
    if (scl_p && bus_a.scl && sda_p && !bus_a.sda)
    begin
      bitc = 0;
      log_q.delete();
    end
    else if (!scl_p && bus_a.scl)
    begin
      sh = {sh[7:0], bus_a.sda};
      bitc++;
      if (bitc == 9)
      begin
        log_q.push_back(sh);
        bitc = 0;
      end
    end
    scl_p = bus_a.scl;
    sda_p = bus_a.sda;
  end
  initial
  begin
    #2400000;
    fail_count++;
    give_verdict();
  end

  ////////////////////////////////////////
  initial
  begin
    logic a, s;
    logic [7:0] n;
    bus_b.host_scl_o = 1'b0;
    bus_b.host_sda_o = 1'b0;
    bus_b.host_scl_oe = 1'b0;
    bus_b.host_sda_oe = 1'b0;
    for (int i = 0; i < 256; i++)
    begin
      rnd = lfsr(rnd);
      regs[i] = rnd;
    end
    repeat (16) @(posedge clk_i);
    #1 rstn_i = 1'b1;
    repeat (4) @(posedge clk_i);
    #1 chk_val(rd_addr_o, 8'h00);
    // Read from the reset pointer, no address write first
    run(1'b1, 1'b0, 7'h08, 8'h00, 8'h01);
    chk_val(rd_got[0], regs[0]);
    chk_log(0, 8'h11, 1'b0);
    chk_log(1, regs[0], 1'b1);
    chk_val(rd_addr_o, 8'h01);
    // Single write at a random register
    rnd = lfsr(rnd);
    n = rnd;
    rnd = lfsr(rnd);
    wr_q.push_back(rnd);
    exp_wq.push_back({n, rnd});
    run(1'b0, 1'b0, 7'h08, n, 8'h01);
    chk_flag(nack_o, 1'b0);
    chk_log(0, 8'h10, 1'b0);
    chk_log(1, n, 1'b0);
    chk_log(2, rnd, 1'b0);
    chk_val(rd_addr_o, n + 8'h01);
    // Stream across the pointer wrap
    for (int i = 0; i < 3; i++)
    begin
      rnd = lfsr(rnd);
      wr_q.push_back(rnd);
      exp_wq.push_back({8'hfe + 8'(i), rnd});
    end
    run(1'b0, 1'b0, 7'h08, 8'hfe, 8'h03);
    chk_val(rd_addr_o, 8'h01);
    drain_wait();
    // Multi-byte read, a read that follows on, then two reads after a pointer reload
    rnd = lfsr(rnd);
    n = rnd;
    rd_got.delete();
    run(1'b1, 1'b1, 7'h08, n, 8'h03);
    for (int i = 0; i < 3; i++)
      chk_val(rd_got[i], regs[8'(n + i)]);
    chk_log(1, regs[n], 1'b0);
    chk_log(3, regs[8'(n + 2)], 1'b1);
    chk_val(rd_addr_o, n + 8'h03);
    rd_got.delete();
    run(1'b1, 1'b0, 7'h08, 8'h00, 8'h01);
    chk_val(rd_got[0], regs[8'(n + 3)]);
    for (int i = 0; i < 2; i++)
    begin
      rd_got.delete();
      run(1'b1, 1'b1, 7'h08, n, 8'h01);
      chk_val(rd_got[0], regs[n]);
    end
    // Every strap setting, clamped above five
    for (int k = 0; k < 8; k++)
    begin
      addr_sel_i = 3'(k);
      repeat (5) @(posedge clk_i);
      #1 rnd = lfsr(rnd);
      run(1'b0, 1'b0, 7'h08 + 7'(k > 5 ? 5 : k), rnd, 8'h00);
      chk_flag(nack_o, 1'b0);
      chk_val(rd_addr_o, rnd);
    end
    run(1'b0, 1'b0, 7'h08, 8'h33, 8'h00);
    chk_flag(nack_o, 1'b1);
    chk_val(rd_addr_o, rnd);
    addr_sel_i = 3'h0;
    bias_power_good_i = 1'b0;
    repeat (5) @(posedge clk_i);
    #1 run(1'b0, 1'b0, 7'h08, 8'h5a, 8'h00);
    chk_flag(nack_o, 1'b1);
    chk_val(rd_addr_o, rnd);
    bias_power_good_i = 1'b1;
    repeat (5) @(posedge clk_i);
    // Fill the write queue until it refuses, then drain
    #1 stall_all = 1'b1;
    n = rnd;
    for (int i = 0; i <= WQ_CAP; i++)
    begin
      rnd = lfsr(rnd);
      wr_q.push_back(rnd);
      if (i < WQ_CAP)
        exp_wq.push_back({8'(n + i), rnd});
    end
    run(1'b0, 1'b0, 7'h08, n, 8'(WQ_CAP + 1));
    chk_flag(nack_o, 1'b1);
    chk_val(rd_addr_o, 8'(n + WQ_CAP));
    chk_flag(wq_valid_o, 1'b1);
    wr_q.delete();
    stall_all = 1'b0;
    drain_wait();
    repeat (3) @(posedge clk_i);
    #1 chk_flag(wq_valid_o, 1'b0);
    // Second bus: read aborted by STOP after the fifth clock
    qq(1'b0, 1'b1);
    qq(1'b1, 1'b1);
    bbyte(8'h10, a);
    chk_flag(a, 1'b0);
    bbyte(8'h40, a);
    qq(1'b1, 1'b1);
    qq(1'b0, 1'b1);
    qq(1'b0, 1'b0);
    chk_val(rd_addr_b, 8'h40);
    qq(1'b0, 1'b1);
    qq(1'b1, 1'b1);
    bbyte(8'h11, a);
    chk_flag(a, 1'b0);
    repeat (4) bbit(1'b1, s);
    chk_val(rd_addr_b, 8'h40);
    bbit(1'b1, s);
    chk_val(rd_addr_b, 8'h41);
    qq(1'b1, 1'b1);
    qq(1'b0, 1'b1);
    qq(1'b0, 1'b0);
    qq(1'b0, 1'b1);
    qq(1'b1, 1'b1);
    bbyte(8'h12, a);
    chk_flag(a, 1'b1);
    qq(1'b1, 1'b1);
    qq(1'b0, 1'b1);
    qq(1'b0, 1'b0);
    chk_val(rd_addr_b, 8'h41);
    give_verdict();
  end
endmodule // i2c_target_register_pointer_tb
`default_nettype wire
